// ===== logic/lpd_pkg.sv
// shared constants and types for the lpddr low-power link
package lpd_pkg;
	localparam int LPD_ADDR_W = 13;
	localparam int LPD_BA_W = 2;
	localparam int LPD_NBANK = 4;
	localparam int LPD_A10 = 10;
	localparam int LPD_CNT_W = 16;
	localparam int CLK_PERIOD_NS = 10;
	localparam int DPD_EXIT_US = 200;
	localparam int DPD_EXIT_CYC = (DPD_EXIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC = 16;
	localparam int STOP_DET_CYC = 2;
	localparam int INIT_LAST = 4;
	localparam logic [LPD_BA_W-1:0] BA_MR = 2'h0;
	localparam logic [LPD_BA_W-1:0] BA_EMR = 2'h2;
	localparam logic [LPD_ADDR_W-1:0] MR_INIT_VAL = 13'h0032;
	localparam logic [LPD_ADDR_W-1:0] EMR_INIT_VAL = 13'h0000;
	localparam logic [LPD_ADDR_W-1:0] MR_RST = 13'h0000;
	// {ras_n, cas_n, we_n} with cs_n low
	typedef enum logic [2:0] {
		CMD_MRS = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} lpd_cmd_t;
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_STOP = 3'h1,
		ST_WAKE = 3'h2,
		ST_DPD = 3'h3,
		ST_XNOP = 3'h4,
		ST_INIT = 3'h5
	} lpd_ctl_state_t;
	typedef enum logic [1:0] {
		DV_IDLE = 2'h0,
		DV_ACTIVE = 2'h1,
		DV_STOP = 2'h2,
		DV_DPD = 2'h3
	} lpd_dev_state_t;
endpackage

// ===== logic/lpd_link_if.sv
// link wires between the controller and the memory device
`timescale 1ns/1ps
interface lpd_link_if import lpd_pkg::*; ();
	logic ck_t;
	logic ck_c;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [LPD_ADDR_W-1:0] addr;
	logic [LPD_BA_W-1:0] ba;
	modport ctl (output ck_t, output ck_c, output cke, output cs_n, output ras_n, output cas_n, output we_n,
		output addr, output ba);
	modport dev (input ck_t, input ck_c, input cke, input cs_n, input ras_n, input cas_n, input we_n,
		input addr, input ba);
endinterface

// ===== logic/lpd_dev.sv
// memory device end: deep power-down and clock-stop behaviour
`timescale 1ns/1ps
module lpd_dev import lpd_pkg::*; (
	input wire logic ref_clk,
	input wire logic nrst,
	lpd_link_if.dev link,
	output lpd_dev_state_t dev_state,
	output logic vgen_on,
	output logic contents_lost,
	output logic [LPD_ADDR_W-1:0] mode_reg,
	output logic [LPD_ADDR_W-1:0] ext_mode_reg,
	output logic mode_valid,
	output logic clk_stopped,
	output logic [LPD_NBANK-1:0] banks_open
);
	logic ck_q_r;
	logic [1:0] low_r;
	logic dpd_r;
	logic mr_ok_r;
	logic emr_ok_r;
	logic rise;
	logic sel;
	lpd_cmd_t cmd;

	// rising edge of the link clock; ignored while parked
	assign rise = link.ck_t & ~ck_q_r;
	assign sel = ~link.cs_n;
	assign cmd = lpd_cmd_t'({link.ras_n, link.cas_n, link.we_n});
	assign mode_valid = mr_ok_r & emr_ok_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ck_q_r <= 1'b0;
		end else begin
			ck_q_r <= link.ck_t;
		end
	end

	// clock parked true low, complement high
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			low_r <= 2'h0;
			clk_stopped <= 1'b0;
		end else begin
			if (!link.ck_t && link.ck_c) begin
				if (low_r != 2'(STOP_DET_CYC))
					low_r <= low_r + 2'h1;
			end else begin
				low_r <= 2'h0;
			end
			clk_stopped <= (low_r == 2'(STOP_DET_CYC));
		end
	end

	// command decode, deep power-down entry and exit
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dpd_r <= 1'b0;
			vgen_on <= 1'b1;
			contents_lost <= 1'b0;
			mode_reg <= MR_RST;
			ext_mode_reg <= MR_RST;
			mr_ok_r <= 1'b0;
			emr_ok_r <= 1'b0;
			banks_open <= '0;
		end else if (rise) begin
			if (dpd_r) begin
				if (link.cke) begin
					dpd_r <= 1'b0;
					vgen_on <= 1'b1;
				end
			end else if (sel && cmd == CMD_BST && !link.cke) begin
				dpd_r <= 1'b1;
				vgen_on <= 1'b0;
				contents_lost <= 1'b1;
				mode_reg <= MR_RST;
				ext_mode_reg <= MR_RST;
				mr_ok_r <= 1'b0;
				emr_ok_r <= 1'b0;
				banks_open <= '0;
			end else if (sel && link.cke) begin
				unique case (cmd)
					CMD_ACT: banks_open[link.ba] <= 1'b1;
					CMD_PRE: begin
						if (link.addr[LPD_A10])
							banks_open <= '0;
						else
							banks_open[link.ba] <= 1'b0;
					end
					CMD_MRS: begin
						if (link.ba == BA_EMR) begin
							ext_mode_reg <= link.addr;
							emr_ok_r <= 1'b1;
						end else begin
							mode_reg <= link.addr;
							mr_ok_r <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dev_state <= DV_IDLE;
		end else if (dpd_r) begin
			dev_state <= DV_DPD;
		end else if (clk_stopped) begin
			dev_state <= DV_STOP;
		end else if (|banks_open) begin
			dev_state <= DV_ACTIVE;
		end else begin
			dev_state <= DV_IDLE;
		end
	end
endmodule

// ===== logic/lpd_ctl.sv
// memory controller end: clock stop, deep power-down entry, exit and re-initialization
`timescale 1ns/1ps
module lpd_ctl import lpd_pkg::*; #(
	parameter int DPD_EXIT_CYCLES = DPD_EXIT_CYC,
	parameter int SETTLE_CYCLES = SETTLE_CYC,
	parameter logic [LPD_ADDR_W-1:0] MR_INIT = MR_INIT_VAL,
	parameter logic [LPD_ADDR_W-1:0] EMR_INIT = EMR_INIT_VAL
) (
	input wire logic ref_clk,
	input wire logic nrst,
	lpd_link_if.ctl link,
	input wire logic req_valid,
	output logic req_ready,
	input wire lpd_cmd_t req_cmd,
	input wire logic [LPD_ADDR_W-1:0] req_addr,
	input wire logic [LPD_BA_W-1:0] req_ba,
	input wire logic dpd_enter_req,
	input wire logic dpd_exit_req,
	input wire logic clk_stop_req,
	output lpd_ctl_state_t ctl_state,
	output logic access_ok,
	output logic [LPD_NBANK-1:0] banks_open
);
	logic ck_r;
	logic ckc_r;
	logic cke_r;
	lpd_cmd_t cmd_r;
	logic [LPD_ADDR_W-1:0] addr_r;
	logic [LPD_BA_W-1:0] ba_r;
	logic [LPD_CNT_W-1:0] settle_r;
	logic [LPD_CNT_W-1:0] xcnt_r;
	logic [2:0] step_r;

	lpd_ctl_state_t st_nxt;
	lpd_cmd_t cmd_nxt;
	logic [LPD_ADDR_W-1:0] addr_nxt;
	logic [LPD_BA_W-1:0] ba_nxt;
	logic cke_nxt;
	logic run_nxt;
	logic [2:0] step_nxt;
	logic slot;
	logic settled;

	// a slot is the edge where ck falls; the new command then holds across the next rise
	assign slot = ck_r;
	assign settled = (settle_r == '0);
	assign req_ready = (ctl_state == ST_RUN) && slot && !dpd_enter_req && !clk_stop_req;
	assign access_ok = (ctl_state == ST_RUN);

	assign link.ck_t = ck_r;
	assign link.ck_c = ckc_r;
	assign link.cke = cke_r;
	assign link.cs_n = 1'b0;
	assign link.ras_n = cmd_r[2];
	assign link.cas_n = cmd_r[1];
	assign link.we_n = cmd_r[0];
	assign link.addr = addr_r;
	assign link.ba = ba_r;

	always_comb begin
		st_nxt = ctl_state;
		cmd_nxt = cmd_r;
		addr_nxt = addr_r;
		ba_nxt = ba_r;
		cke_nxt = cke_r;
		run_nxt = 1'b1;
		step_nxt = step_r;
		if (slot)
			cmd_nxt = CMD_NOP;
		unique case (ctl_state)
			ST_RUN: begin
				if (slot) begin
					if (dpd_enter_req) begin
						if (!settled) begin
							cmd_nxt = CMD_NOP;
						end else if (|banks_open) begin
							cmd_nxt = CMD_PRE;
							addr_nxt = '0;
							addr_nxt[LPD_A10] = 1'b1;
						end else begin
							cmd_nxt = CMD_BST;
							cke_nxt = 1'b0;
							st_nxt = ST_DPD;
						end
					end else if (clk_stop_req) begin
						if (settled)
							st_nxt = ST_STOP;
					end else if (req_valid) begin
						cmd_nxt = req_cmd;
						addr_nxt = req_addr;
						ba_nxt = req_ba;
					end
				end
			end
			ST_STOP: begin
				run_nxt = 1'b0;
				if (!clk_stop_req || dpd_enter_req)
					st_nxt = ST_WAKE;
			end
			ST_WAKE: begin
				if (slot)
					st_nxt = ST_RUN;
			end
			ST_DPD: begin
				cke_nxt = 1'b0;
				if (slot && dpd_exit_req) begin
					cke_nxt = 1'b1;
					st_nxt = ST_XNOP;
				end
			end
			ST_XNOP: begin
				if (slot && xcnt_r == '0) begin
					st_nxt = ST_INIT;
					step_nxt = 3'h0;
				end
			end
			ST_INIT: begin
				if (slot && settled) begin
					unique case (step_r)
						3'h0: begin
							cmd_nxt = CMD_PRE;
							addr_nxt = '0;
							addr_nxt[LPD_A10] = 1'b1;
						end
						3'h1, 3'h2: cmd_nxt = CMD_REF;
						3'h3: begin
							cmd_nxt = CMD_MRS;
							addr_nxt = MR_INIT;
							ba_nxt = BA_MR;
						end
						default: begin
							cmd_nxt = CMD_MRS;
							addr_nxt = EMR_INIT;
							ba_nxt = BA_EMR;
						end
					endcase
					step_nxt = step_r + 3'h1;
					if (step_r == 3'(INIT_LAST))
						st_nxt = ST_RUN;
				end
			end
			default: st_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_state <= ST_RUN;
			step_r <= 3'h0;
		end else begin
			ctl_state <= st_nxt;
			step_r <= step_nxt;
		end
	end

	// link clock: halves of the reference rate, parked true low in stop
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ck_r <= 1'b0;
			ckc_r <= 1'b1;
		end else begin
			ck_r <= run_nxt ? ~ck_r : 1'b0;
			ckc_r <= run_nxt ? ck_r : 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_r <= CMD_NOP;
			addr_r <= '0;
			ba_r <= '0;
			cke_r <= 1'b1;
		end else begin
			cmd_r <= cmd_nxt;
			addr_r <= addr_nxt;
			ba_r <= ba_nxt;
			cke_r <= cke_nxt;
		end
	end

	// each issued command must complete before stop or deep power-down
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			settle_r <= '0;
		end else if (slot && cmd_nxt != CMD_NOP) begin
			settle_r <= LPD_CNT_W'(SETTLE_CYCLES);
		end else if (!settled) begin
			settle_r <= settle_r - 1'b1;
		end
	end

	// nop interval after cke rises on exit
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			xcnt_r <= '0;
		end else if (ctl_state == ST_DPD && st_nxt == ST_XNOP) begin
			xcnt_r <= LPD_CNT_W'(DPD_EXIT_CYCLES);
		end else if (xcnt_r != '0) begin
			xcnt_r <= xcnt_r - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			banks_open <= '0;
		end else if (slot) begin
			unique case (cmd_nxt)
				CMD_ACT: banks_open[ba_nxt] <= 1'b1;
				CMD_PRE: begin
					if (addr_nxt[LPD_A10])
						banks_open <= '0;
					else
						banks_open[ba_nxt] <= 1'b0;
				end
				default: ;
			endcase
		end
	end
endmodule

// ===== verif/lpd_chk.sv
// assertions on the link between controller and device
`timescale 1ns/1ps
module lpd_chk import lpd_pkg::*; (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ck_t,
	input wire logic ck_c,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [LPD_ADDR_W-1:0] addr,
	input wire logic [LPD_BA_W-1:0] ba
);
	wire logic [2:0] c = {ras_n, cas_n, we_n};
	logic cke_q_r;
	logic exited_r;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// marks the stretch from cke rising on exit up to the first real command
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cke_q_r <= 1'b1;
			exited_r <= 1'b0;
		end else begin
			cke_q_r <= cke;
			if (cke && !cke_q_r)
				exited_r <= 1'b1;
			else if (c != CMD_NOP)
				exited_r <= 1'b0;
		end
	end
	AST_DPD_ENTRY: assert property ($fell(cke) |-> c == CMD_BST)
		else $error("cke fell without burst terminate");
	AST_DPD_IDLE: assert property ($fell(cke) |-> $past(c) == CMD_NOP && $past(c, 2) == CMD_NOP)
		else $error("entry not preceded by quiet bus");
	AST_DPD_HOLD: assert property (!cke |-> c == CMD_NOP || c == CMD_BST)
		else $error("command issued while cke low");
	AST_EXIT_NOP: assert property ($rose(cke) |-> (c == CMD_NOP) [*8])
		else $error("command too soon after exit");
	AST_CK_PARK: assert property (ck_c == !ck_t)
		else $error("clock pair not complementary");
	AST_STOP_CKE: assert property (!ck_t && $past(!ck_t) |-> cke)
		else $error("clock stopped with cke low");
	AST_CMD_DONE: assert property (c != CMD_NOP && cke && !ck_t |=> ck_t ##1 !ck_t ##1 ck_t)
		else $error("clock stopped before command completed");
	AST_RESTART: assert property (!ck_t && $past(!ck_t) ##1 ck_t |-> c == CMD_NOP)
		else $error("first edge after restart not a nop");
	AST_REINIT_PRE: assert property (exited_r && c != CMD_NOP |-> c == CMD_PRE && addr[LPD_A10])
		else $error("re-initialization not opened by precharge all");
	AST_CMD_SEL: assert property (c != CMD_NOP |-> !cs_n)
		else $error("command issued without chip select");
endmodule

// ===== verif/testbench.sv
// self-checking bench for the low-power link
`timescale 1ns/1ps
module testbench import lpd_pkg::*;;
	logic ref_clk = 0;
	logic nrst = 0;
	logic req_valid = 0;
	lpd_cmd_t req_cmd = CMD_NOP;
	logic [12:0] req_addr = 0;
	logic [1:0] req_ba = 0;
	logic dpd_enter_req = 0;
	logic dpd_exit_req = 0;
	logic clk_stop_req = 0;
	logic req_ready, access_ok, vgen_on, contents_lost, mode_valid, clk_stopped;
	lpd_ctl_state_t ctl_state;
	lpd_dev_state_t dev_state;
	logic [3:0] banks_open, dev_banks;
	logic [12:0] mode_reg, ext_mode_reg, mr;
	logic [17:0] expq[$];
	int num_errors = 0;
	int n_compared = 0;
	lpd_link_if link();
	lpd_ctl #(.DPD_EXIT_CYCLES(40), .SETTLE_CYCLES(4)) lpd_ctl_i (.ref_clk, .nrst, .link, .req_valid,
		.req_ready, .req_cmd, .req_addr, .req_ba, .dpd_enter_req, .dpd_exit_req, .clk_stop_req,
		.ctl_state, .access_ok, .banks_open);
	lpd_dev lpd_dev_i (.ref_clk, .nrst, .link, .dev_state, .vgen_on, .contents_lost, .mode_reg,
		.ext_mode_reg, .mode_valid, .clk_stopped, .banks_open(dev_banks));
	lpd_chk lpd_chk_i (.ref_clk, .nrst, .ck_t(link.ck_t), .ck_c(link.ck_c), .cke(link.cke),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.addr(link.addr), .ba(link.ba));
	always #5 ref_clk = ~ref_clk;
	task automatic test_done;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic err(input string s);
		num_errors++;
		$display("ERROR %0t %s", $time, s);
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
		n_compared++;
		if (g !== e) err(s);
	endtask
	// ba and addr only matter where the command uses them
	task automatic cmp_cmd(input logic [17:0] e, input logic [17:0] g);
		logic [17:0] m;
		m = e[17:15] inside {CMD_REF, CMD_BST} ? 18'h38000 : e[17:15] != CMD_PRE ? 18'h3FFFF :
			e[10] ? 18'h38400 : 18'h3E400;
		n_compared++;
		if ((g & m) !== (e & m)) err($sformatf("cmd %h expected %h", g, e));
	endtask
	task automatic wait_st(input lpd_ctl_state_t s);
		for (int i = 0; i < 900 && ctl_state !== s; i++) @(negedge ref_clk);
		if (ctl_state !== s) begin
			err("state wait timed out");
			test_done;
		end
	endtask
	task automatic req(input lpd_cmd_t cmd, input logic [12:0] a, input logic [1:0] b);
		@(posedge ref_clk);
		req_valid <= 1;
		req_cmd <= cmd;
		req_addr <= a;
		req_ba <= b;
		@(negedge ref_clk);
		for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge ref_clk);
		if (req_ready !== 1'b1) begin
			err("request never taken");
			test_done;
		end
		expq.push_back({cmd, b, a});
		@(posedge ref_clk);
		req_valid <= 0;
	endtask
	// a command is seen in the ref cycle after launch, while ck_t is still low
	always @(posedge ref_clk) begin
		if (nrst && !link.ck_t && {link.ras_n, link.cas_n, link.we_n} != CMD_NOP) begin
			if (expq.size() == 0) err("unexpected command");
			else cmp_cmd(expq.pop_front(), {link.ras_n, link.cas_n, link.we_n, link.ba, link.addr});
		end
	end
	initial begin
		void'($urandom(32'h17E76B2D));
		repeat (20) @(posedge ref_clk);
		nrst <= 1;
		mr = 13'($urandom);
		req(CMD_MRS, mr, BA_MR);
		req(CMD_MRS, 13'($urandom), BA_EMR);
		for (int k = 0; k < 3; k++) req(CMD_ACT, 13'($urandom), 2'(k));
		req(CMD_WR, 13'($urandom) & 13'h1BFF, 2'h1);
		req(CMD_RD, 13'($urandom) & 13'h1BFF, 2'h0);
		chk(mode_reg, mr, "mode reg load");
		chk(mode_valid, 1, "mode valid");
		@(posedge ref_clk);
		clk_stop_req <= 1;
		wait_st(ST_STOP);
		repeat (5) @(negedge ref_clk);
		chk(clk_stopped, 1, "clock stop seen");
		chk(dev_state, DV_STOP, "device stopped");
		@(posedge ref_clk);
		clk_stop_req <= 0;
		wait_st(ST_RUN);
		req(CMD_PRE, 13'h0000, 2'h2);
		repeat (3) @(negedge ref_clk);
		chk(dev_state, DV_ACTIVE, "device resumed");
		chk(dev_banks, 4'h3, "open banks");
		chk(banks_open, 4'h3, "ctl open banks");
		@(posedge ref_clk);
		dpd_enter_req <= 1;
		expq.push_back({CMD_PRE, 2'h0, 13'h0400});
		expq.push_back({CMD_BST, 15'h0000});
		wait_st(ST_DPD);
		@(posedge ref_clk);
		dpd_enter_req <= 0;
		repeat (4) @(negedge ref_clk);
		chk(vgen_on, 0, "generators off");
		chk(contents_lost, 1, "contents lost");
		chk(mode_reg, 0, "mode reg kept");
		chk(ext_mode_reg, 0, "ext mode reg kept");
		chk(dev_state, DV_DPD, "device not powered down");
		chk(dev_banks, 0, "banks left open");
		chk(banks_open, 0, "ctl banks left open");
		chk(req_ready, 0, "ready in power-down");
		chk(access_ok, 0, "access in power-down");
		@(posedge ref_clk);
		dpd_exit_req <= 1;
		expq.push_back({CMD_PRE, 2'h0, 13'h0400});
		repeat (2) expq.push_back({CMD_REF, 15'h0000});
		expq.push_back({CMD_MRS, BA_MR, MR_INIT_VAL});
		expq.push_back({CMD_MRS, BA_EMR, EMR_INIT_VAL});
		wait_st(ST_XNOP);
		@(posedge ref_clk);
		dpd_exit_req <= 0;
		wait_st(ST_RUN);
		repeat (4) @(negedge ref_clk);
		chk(16'(expq.size()), 0, "init commands missing");
		chk(mode_reg, MR_INIT_VAL, "mode reg reload");
		chk(ext_mode_reg, EMR_INIT_VAL, "ext mode reg reload");
		chk(mode_valid, 1, "mode not valid");
		chk(vgen_on, 1, "generators still off");
		chk(access_ok, 1, "access blocked");
		test_done;
	end
endmodule
